// >>> rtl/eti_injector.sv
// Transmit error and alarm injector with AXI4-Lite control
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// RULE_01: Alarm held continuously while enabled, no counting
// RULE_02: Off mode passes stream unmodified
// RULE_03: Manual trigger injects exactly burst-length errors
// RULE_04: Per-second mode injects burst each second
// RULE_05: Per-ten-second mode injects burst each ten seconds
// RULE_06: Rate mode injects burst per 10^n blocks
// RULE_07: Rate modes ignore trigger; indicator shows activity
// RULE_08: Software supplies the burst-length count
// RULE_09: Gap destination requests a shortened inter-frame gap
// RULE_10: Frame check destination corrupts the FCS
// RULE_11: Preamble corrupted only at 10G or below
// RULE_12: IP destination corrupts the IPv4 header checksum
// RULE_13: Fragmentation destination requests fragmented IPv4 data
// RULE_14: Transport destination corrupts TCP/UDP checksum
// RULE_15: Pattern destination flips payload pattern bits
// RULE_16: Sequence destination corrupts the sequence number
// RULE_17: Symbol destination at 10G sends invalid block
// RULE_18: Symbol destination at 1G raises TX_ER
// RULE_19: FEC symbol error only with FEC enabled
// RULE_20: Flow-control destination requests PAUSE frames
// RULE_21: Changing mode or destination cancels pending insertion
module eti_injector #(
  parameter int unsigned SEC_CYCLES = 125000000
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire eti_pkg::eti_beat_type in_beat,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  output eti_pkg::eti_beat_type      out_beat,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output eti_pkg::eti_gen_req_type   gen_req,
  output logic                       alarm_active
);
  `include "eti_regs.svh"

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [31:0]           ctrl;         // Control register
  logic [15:0]           burst;        // Errors per insertion event
  eti_pkg::eti_speed_type speed;       // Line rate class
  logic [31:0]           err_count;    // Errors inserted so far
  logic [15:0]           pending;      // Errors still to insert
  logic [23:0]           blk_cnt;      // Blocks since last rate event
  logic [7:0]            aw_addr;      // Held write address
  logic                  aw_held;      // Write address captured
  logic [31:0]           w_data;       // Held write data
  logic [3:0]            w_strb;       // Held write strobes
  logic                  w_held;       // Write data captured
  logic                  commit;       // Write performed this cycle
  logic [31:0]           next_ctrl;    // Control after strobe merge
  logic [31:0]           next_burst;   // Burst word after strobe merge
  logic                  cancel;       // Setting changed
  logic                  trig;         // Manual insert pulse
  logic                  tick_sec;     // One-second period
  logic                  tick_tensec;  // Ten-second period
  eti_pkg::eti_mode_type  mode;
  eti_pkg::eti_dest_type  dest;
  logic                  dest_ok;      // Destination legal now
  logic                  ins_on;       // Insertion armed
  logic                  is_rate;      // Rate mode selected
  logic                  is_req;       // Frame request destination
  logic                  inj_en;       // Errors outstanding
  logic                  rate_hit;     // Rate interval completed
  logic                  load_burst;   // Insertion event
  logic                  load;         // Input beat taken
  logic                  hit;          // Beat receives an error
  eti_pkg::eti_beat_type  next_beat;   // Beat after corruption

  // Byte-strobe merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign commit        = aw_held && w_held && !s_axi_bvalid;
  assign next_ctrl     = merge(ctrl, w_data, w_strb);
  assign next_burst    = merge({16'h0, burst}, w_data, w_strb);
  assign mode          = eti_pkg::eti_mode_type'(ctrl[`ETI_CTRL_MODE_MSB:`ETI_CTRL_MODE_LSB]);
  assign dest          = eti_pkg::eti_dest_type'(ctrl[`ETI_CTRL_DEST_MSB:`ETI_CTRL_DEST_LSB]);
  // Mode or destination change drops what is pending
  assign cancel = commit && (aw_addr == `ETI_OFF_CTRL) &&
                  (next_ctrl[`ETI_CTRL_DEST_MSB:`ETI_CTRL_MODE_LSB] !=
                   ctrl[`ETI_CTRL_DEST_MSB:`ETI_CTRL_MODE_LSB]);  // [RULE_21]
  assign trig   = commit && (aw_addr == `ETI_OFF_TRIGGER) && w_strb[0] && w_data[0];

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (commit) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (commit) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ETI_RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= `ETI_OFF_COUNT) ? `ETI_RESP_OKAY : `ETI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl  <= `ETI_CTRL_RST;
      burst <= `ETI_BURST_RST;
      speed <= eti_pkg::eti_speed_type'(`ETI_LINE_RST);
    end else if (commit) begin
      if (aw_addr == `ETI_OFF_CTRL) begin
        ctrl <= next_ctrl & 32'h0000_1ff1;
      end
      if (aw_addr == `ETI_OFF_BURST) begin
        burst <= next_burst[15:0];  // [RULE_08]
      end
      if (aw_addr == `ETI_OFF_LINE && w_strb[0]) begin
        speed <= eti_pkg::eti_speed_type'(w_data[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Read data mux, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `ETI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `ETI_RESP_OKAY;
      unique case (s_axi_araddr)
        `ETI_OFF_CTRL:    s_axi_rdata <= ctrl;
        `ETI_OFF_BURST:   s_axi_rdata <= {16'h0, burst};
        `ETI_OFF_TRIGGER: s_axi_rdata <= 32'h0;
        `ETI_OFF_STATUS:  s_axi_rdata <= {pending, 14'h0, inj_en, ins_on};  // [RULE_07]
        `ETI_OFF_LINE:    s_axi_rdata <= {30'h0, speed};
        `ETI_OFF_COUNT:   s_axi_rdata <= err_count;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `ETI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Insertion control
  // ----------------------------------------------------------------------------
  eti_period_gen #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_period (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clr         (cancel),
    .tick_sec    (tick_sec),
    .tick_tensec (tick_tensec)
  );

  // Destination legality against line rate and FEC
  always_comb begin
    unique case (dest)
      eti_pkg::ETI_DST_PRE: dest_ok = (speed == eti_pkg::ETI_SPD_LOW) || (speed == eti_pkg::ETI_SPD_10G);  // [RULE_11]
      eti_pkg::ETI_DST_SYM: dest_ok = (speed == eti_pkg::ETI_SPD_LOW) || (speed == eti_pkg::ETI_SPD_10G);
      eti_pkg::ETI_DST_FEC: dest_ok = ctrl[`ETI_CTRL_FEC] &&
                                      ((speed == eti_pkg::ETI_SPD_25G) || (speed == eti_pkg::ETI_SPD_100G));  // [RULE_19]
      default:              dest_ok = (dest <= eti_pkg::ETI_DST_FEC);
    endcase
  end

  assign is_rate    = (mode >= eti_pkg::ETI_MODE_E2) && (mode <= eti_pkg::ETI_MODE_E7);
  assign is_req     = (dest == eti_pkg::ETI_DST_IFG) || (dest == eti_pkg::ETI_DST_PAUSE) || (dest == eti_pkg::ETI_DST_FRAG);
  // Alarm selection and off mode disarm error insertion
  assign ins_on     = !ctrl[`ETI_CTRL_ALARM] && (mode != eti_pkg::ETI_MODE_OFF) && dest_ok;  // [RULE_02]
  assign inj_en     = ins_on && (pending != 16'h0);
  assign rate_hit   = is_rate && load && (blk_cnt == eti_pkg::eti_rate_div(mode) - 24'h1);  // [RULE_06]
  assign load_burst = ins_on && (((mode == eti_pkg::ETI_MODE_MANUAL) && trig) ||  // [RULE_03] [RULE_07]
                                 ((mode == eti_pkg::ETI_MODE_SEC) && tick_sec) ||  // [RULE_04]
                                 ((mode == eti_pkg::ETI_MODE_TENSEC) && tick_tensec) ||  // [RULE_05]
                                 rate_hit);

  // Block counter for rate modes
  always_ff @(posedge aclk) begin
    if (!aresetn || cancel || !is_rate) begin
      blk_cnt <= 24'h0;
    end else if (rate_hit) begin
      blk_cnt <= 24'h0;
    end else if (load) begin
      blk_cnt <= blk_cnt + 24'h1;
    end
  end

  // Outstanding errors: cancel, then a new event, then consumption
  always_ff @(posedge aclk) begin
    if (!aresetn || cancel) begin
      pending <= 16'h0;  // [RULE_21]
    end else if (load_burst) begin
      pending <= burst;  // [RULE_03] [RULE_04] [RULE_05] [RULE_06]
    end else if (hit) begin
      pending <= pending - 16'h1;
    end
  end

  // Inserted error counter and alarm level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_count    <= 32'h0;
      alarm_active <= 1'b0;
    end else begin
      alarm_active <= ctrl[`ETI_CTRL_ALARM];  // [RULE_01]
      if (hit) begin
        err_count <= err_count + 32'h1;
      end
    end
  end

  // Frame requests toward the generator
  always_ff @(posedge aclk) begin
    if (!aresetn || cancel) begin
      gen_req <= '0;
    end else begin
      gen_req.short_ifg <= inj_en && (dest == eti_pkg::ETI_DST_IFG);  // [RULE_09]
      gen_req.pause     <= inj_en && (dest == eti_pkg::ETI_DST_PAUSE);  // [RULE_20]
      gen_req.fragment  <= inj_en && (dest == eti_pkg::ETI_DST_FRAG);  // [RULE_13]
    end
  end

  // ----------------------------------------------------------------------------
  // Stream stage
  // ----------------------------------------------------------------------------
  assign in_ready = !out_valid || out_ready;
  assign load     = in_valid && in_ready;
  assign hit      = load && inj_en && !cancel && (is_req ? (in_beat.sof && (gen_req != '0)) : in_beat.tags[dest]);

  // Corruption of the tagged beat
  always_comb begin
    next_beat = in_beat;
    if (hit) begin
      unique case (dest)
        eti_pkg::ETI_DST_FCS,  // [RULE_10]
        eti_pkg::ETI_DST_PRE,  // [RULE_11]
        eti_pkg::ETI_DST_IPCS,  // [RULE_12]
        eti_pkg::ETI_DST_L4CS,  // [RULE_14]
        eti_pkg::ETI_DST_PAT,  // [RULE_15]
        eti_pkg::ETI_DST_SEQ: next_beat.data = in_beat.data ^ `ETI_FLIP_MASK;  // [RULE_16]
        eti_pkg::ETI_DST_SYM: begin
          if (speed == eti_pkg::ETI_SPD_10G) begin
            next_beat.sync_hdr = `ETI_BAD_SYNC;  // [RULE_17]
          end else begin
            next_beat.tx_er = 1'b1;  // [RULE_18]
          end
        end
        eti_pkg::ETI_DST_FEC: next_beat.data = in_beat.data ^ `ETI_FEC_MASK;  // [RULE_19]
        default: next_beat = in_beat;
      endcase
    end
  end

  // Output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_beat  <= '0;
    end else if (in_ready) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_beat <= next_beat;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ALARM_HOLD: assert property (ctrl[`ETI_CTRL_ALARM] && $past(ctrl[`ETI_CTRL_ALARM]) |-> alarm_active && !inj_en) // [RULE_01]
    else $error("Alarm not held or errors counted");
  AST_OFF_PASS: assert property ($past(load) && $past(mode) == eti_pkg::ETI_MODE_OFF |-> out_beat == $past(in_beat)) // [RULE_02]
    else $error("Off mode altered the stream");
  AST_MANUAL_LOAD: assert property (ins_on && mode == eti_pkg::ETI_MODE_MANUAL && trig |=> pending == $past(burst)) // [RULE_03]
    else $error("Manual trigger did not load burst");
  AST_SEC_LOAD: assert property (ins_on && mode == eti_pkg::ETI_MODE_SEC && tick_sec && !cancel |=> pending == $past(burst)) // [RULE_04]
    else $error("Second tick did not load burst");
  AST_TENSEC_LOAD: assert property (mode == eti_pkg::ETI_MODE_TENSEC && tick_tensec && ins_on && !cancel |=> pending == $past(burst)) // [RULE_05]
    else $error("Ten-second tick did not load burst");
  AST_RATE_LOAD: assert property (rate_hit && ins_on && !cancel |=> pending == $past(burst) && blk_cnt == 24'h0) // [RULE_06]
    else $error("Rate interval did not load burst");
  AST_RATE_NO_TRIG: assert property (is_rate && trig && !rate_hit && !hit && !cancel |=> pending == $past(pending)) // [RULE_07]
    else $error("Trigger acted in rate mode");
  AST_CONSUME: assert property (hit && !load_burst |=> pending == $past(pending) - 16'h1 && err_count == $past(err_count) + 32'h1) // [RULE_03]
    else $error("Inserted error not counted once");
  AST_FCS_FLIP: assert property ($past(hit) && $past(dest) == eti_pkg::ETI_DST_FCS |-> out_beat.data == ($past(in_beat.data) ^ `ETI_FLIP_MASK)) // [RULE_10]
    else $error("Frame check not corrupted");
  AST_TXER: assert property ($past(hit) && $past(dest) == eti_pkg::ETI_DST_SYM && $past(speed) == eti_pkg::ETI_SPD_LOW |-> out_beat.tx_er) // [RULE_18]
    else $error("TX_ER missing on errored symbol");
  AST_FEC_GATE: assert property (dest == eti_pkg::ETI_DST_FEC && !ctrl[`ETI_CTRL_FEC] |-> !ins_on ##1 !$rose(err_count[0])) // [RULE_19]
    else $error("FEC error without FEC enabled");
  AST_CANCEL: assert property (cancel |=> pending == 16'h0 ##1 gen_req == '0) // [RULE_21]
    else $error("Setting change left insertion pending");

  COV_MANUAL: cover property (mode == eti_pkg::ETI_MODE_MANUAL && trig ##[1:20] hit);
  COV_RATE: cover property (rate_hit && ins_on);
  COV_SEC: cover property (tick_sec && ins_on);
  COV_CANCEL: cover property (inj_en && cancel);

endmodule : eti_injector

// >>> shared/eti_regs.svh
// Register offsets, field positions, reset values and timing counts of the error injector
`ifndef ETI_REGS_SVH
`define ETI_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ETI_OFF_CTRL      8'h00
`define ETI_OFF_BURST     8'h04
`define ETI_OFF_TRIGGER   8'h08
`define ETI_OFF_STATUS    8'h0c
`define ETI_OFF_LINE      8'h10
`define ETI_OFF_COUNT     8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ETI_CTRL_ALARM    0
`define ETI_CTRL_MODE_LSB 4
`define ETI_CTRL_MODE_MSB 7
`define ETI_CTRL_DEST_LSB 8
`define ETI_CTRL_DEST_MSB 11
`define ETI_CTRL_FEC      12
`define ETI_STAT_ACTIVE   0
`define ETI_STAT_BUSY     1
`define ETI_STAT_PEND_LSB 16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ETI_CTRL_RST      32'h0000_0100
`define ETI_BURST_RST     16'h0001
`define ETI_LINE_RST      2'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ETI_CLK_PERIOD_PS 64'd8000
`define ETI_PERIOD_1S_MS  64'd1000
`define ETI_SEC_CYCLES    ((`ETI_PERIOD_1S_MS * 64'd1000000000) / `ETI_CLK_PERIOD_PS)
`define ETI_TEN_SEC_TICKS 4'ha

// ----------------------------------------------------------------------------
// Corruption patterns and bus answers
// ----------------------------------------------------------------------------
`define ETI_FLIP_MASK     64'h0000_0000_0000_0001
`define ETI_FEC_MASK      64'h0000_0000_0000_03ff
`define ETI_BAD_SYNC      2'h0
`define ETI_RESP_OKAY     2'h0
`define ETI_RESP_SLVERR   2'h2

`endif

// >>> shared/eti_pkg.sv
// Types shared by the error injector modules
package eti_pkg;

  // ----------------------------------------------------------------------------
  // Insertion modes
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ETI_MODE_OFF    = 4'h0,
    ETI_MODE_MANUAL = 4'h1,
    ETI_MODE_SEC    = 4'h2,
    ETI_MODE_TENSEC = 4'h3,
    ETI_MODE_E2     = 4'h4,
    ETI_MODE_E3     = 4'h5,
    ETI_MODE_E4     = 4'h6,
    ETI_MODE_E5     = 4'h7,
    ETI_MODE_E6     = 4'h8,
    ETI_MODE_E7     = 4'h9
  } eti_mode_type;

  // ----------------------------------------------------------------------------
  // Destinations, index equals tag bit
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ETI_DST_IFG   = 4'h0,
    ETI_DST_FCS   = 4'h1,
    ETI_DST_PRE   = 4'h2,
    ETI_DST_PAUSE = 4'h3,
    ETI_DST_IPCS  = 4'h4,
    ETI_DST_FRAG  = 4'h5,
    ETI_DST_L4CS  = 4'h6,
    ETI_DST_PAT   = 4'h7,
    ETI_DST_SEQ   = 4'h8,
    ETI_DST_SYM   = 4'h9,
    ETI_DST_FEC   = 4'ha
  } eti_dest_type;

  typedef enum logic [1:0] {
    ETI_SPD_LOW  = 2'h0,   // 1 Gbps or below
    ETI_SPD_10G  = 2'h1,
    ETI_SPD_25G  = 2'h2,
    ETI_SPD_100G = 2'h3
  } eti_speed_type;

  // One transmit beat with its generator tags
  typedef struct packed {
    logic [63:0] data;
    logic [1:0]  sync_hdr;
    logic [10:0] tags;
    logic        sof;
    logic        eof;
    logic        tx_er;
  } eti_beat_type;

  // Frame-level requests toward the generator
  typedef struct packed {
    logic short_ifg;
    logic pause;
    logic fragment;
  } eti_gen_req_type;

  // Blocks between rate insertion events
  function automatic logic [23:0] eti_rate_div(input eti_mode_type mode);
    unique case (mode)
      ETI_MODE_E2: eti_rate_div = 24'h00_0064;
      ETI_MODE_E3: eti_rate_div = 24'h00_03e8;
      ETI_MODE_E4: eti_rate_div = 24'h00_2710;
      ETI_MODE_E5: eti_rate_div = 24'h01_86a0;
      ETI_MODE_E6: eti_rate_div = 24'h0f_4240;
      ETI_MODE_E7: eti_rate_div = 24'h98_9680;
      default:     eti_rate_div = 24'h00_0001;
    endcase
  endfunction : eti_rate_div

endpackage : eti_pkg

// >>> rtl/eti_period_gen.sv
// One-second and ten-second tick divider
`timescale 1ns/1ps
module eti_period_gen #(
  parameter int unsigned SEC_CYCLES = 125000000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clr,
  output logic      tick_sec,
  output logic      tick_tensec
);
  `include "eti_regs.svh"

  logic [31:0] cyc_cnt;  // Cycles within the second
  logic [3:0]  sec_cnt;  // Seconds within ten
  logic        sec_end;  // Last cycle of the second

  assign sec_end = (cyc_cnt == 32'(SEC_CYCLES - 1));

  // Cycle counter, restarts on clear
  always_ff @(posedge aclk) begin
    if (!aresetn || clr || sec_end) begin
      cyc_cnt <= 32'h0;
    end else begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  // Second ticks and decade counting
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      sec_cnt     <= 4'h0;
      tick_sec    <= 1'b0;
      tick_tensec <= 1'b0;
    end else begin
      tick_sec    <= sec_end;
      tick_tensec <= sec_end && (sec_cnt == `ETI_TEN_SEC_TICKS - 4'h1);
      if (sec_end) begin
        sec_cnt <= (sec_cnt == `ETI_TEN_SEC_TICKS - 4'h1) ? 4'h0 : sec_cnt + 4'h1;
      end
    end
  end

endmodule : eti_period_gen

// >>> sim/eti_tx_sink.sv
// Far-side transmit path model with random stalls
`timescale 1ns/1ps
module eti_tx_sink (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      out_ready
);
  // Ready drops about one cycle in four
  always_ff @(posedge aclk) begin
    out_ready <= aresetn && ($urandom % 4 != 0);
  end
endmodule : eti_tx_sink

// >>> sim/tb.sv
// Self-checking bench of the error injector
`timescale 1ns/1ps
`include "eti_regs.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  // ----------------------------------------------------------------------------
  // Signals, named as the ports
  // ----------------------------------------------------------------------------
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, in_valid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, in_ready, out_valid, out_ready, alarm_active;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  eti_pkg::eti_beat_type    in_beat = '0, out_beat, b, e, m;
  eti_pkg::eti_beat_type    q[$];    // Expected beats
  eti_pkg::eti_gen_req_type gen_req;
  int fails = 0, check_count = 0;
  logic [3:0] dl[10] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'h2, 4'ha}; // Destinations
  logic [1:0] ln[10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2}; // Line speeds
  eti_pkg::eti_mode_type md;
  eti_injector #(.SEC_CYCLES(50)) DUT (.*);
  eti_tx_sink SNK (.aclk(aclk), .aresetn(aresetn), .out_ready(out_ready));
  initial forever #4 aclk = ~aclk;
  // ----------------------------------------------------------------------------
  // Bus and stream tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
    {ta, tw} = 2'b00;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    `CHK("rdata", x, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
    @(posedge aclk);
  endtask : rd
  // Send one beat and note its expected corrupted form
  task automatic send(input logic [10:0] t, input logic hit, input logic [3:0] d, input logic [1:0] s);
    b = '0;
    b.data = {$urandom, $urandom};
    b.sync_hdr = 2'h1;
    b.tags = t;
    e = b;
    if (hit && d == 4'h9 && s == 2'h0) e.tx_er = 1'b1;
    else if (hit && d == 4'h9) e.sync_hdr = `ETI_BAD_SYNC;
    else if (hit) e.data = b.data ^ `ETI_FLIP_MASK;
    q.push_back(e);
    {in_beat, in_valid} <= {b, 1'b1};
    do @(negedge aclk); while (!in_ready);
    @(posedge aclk);
  endtask : send
  task automatic drain(input string n);
    int w;
    in_valid <= 1'b0;
    for (w = 0; w < 100 && q.size() != 0; w++) @(posedge aclk);
    `CHK("drained", 1'b1, q.size() == 0)
    $display("test %s done", n);
  endtask : drain
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Output watcher compares against oldest note
  always @(posedge aclk) if (aresetn && out_valid && out_ready) begin
    m = q.size() ? q.pop_front() : '1;
    `CHK("out_beat", m, out_beat)
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    close_out();
  end
  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(15716));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ETI_OFF_CTRL, `ETI_CTRL_RST, `ETI_RESP_OKAY);
    rd(8'h40, 32'h0, `ETI_RESP_SLVERR);
    repeat (3) send(11'h7ff, 1'b0, 4'h0, 2'h1);
    drain("off");
    wr(`ETI_OFF_BURST, 32'h2);
    foreach (dl[i]) begin
      wr(`ETI_OFF_LINE, {30'h0, ln[i]});
      wr(`ETI_OFF_CTRL, {20'h0, dl[i], 8'h10});
      wr(`ETI_OFF_TRIGGER, 32'h1);
      for (int k = 0; k < 3; k++) send(11'h1 << dl[i], k < 2 && ln[i] < 2, dl[i], ln[i]);
      drain("manual");
    end
    wr(`ETI_OFF_CTRL, 32'h0000_0310);
    wr(`ETI_OFF_TRIGGER, 32'h1);
    @(negedge aclk);
    `CHK("gen_req", 3'b010, gen_req)
    @(posedge aclk);
    for (md = eti_pkg::ETI_MODE_E2; md <= eti_pkg::ETI_MODE_E7; md = md.next()) begin
      wr(`ETI_OFF_CTRL, {24'h1, md, 4'h0});
      wr(`ETI_OFF_TRIGGER, 32'h1);
      for (int k = 0; k < (md == eti_pkg::ETI_MODE_E2 ? 103 : 3); k++)
        send(11'h2, md == eti_pkg::ETI_MODE_E2 && (k == 100 || k == 101), 4'h1, 2'h1);
      drain("rate");
      rd(`ETI_OFF_STATUS, 32'h1, `ETI_RESP_OKAY);
      if (md == eti_pkg::ETI_MODE_E7) break;
    end
    wr(`ETI_OFF_CTRL, 32'h0000_0120);
    repeat (60) @(posedge aclk);
    rd(`ETI_OFF_STATUS, 32'h0002_0003, `ETI_RESP_OKAY);
    wr(`ETI_OFF_CTRL, 32'h0000_0130);
    repeat (60) @(posedge aclk);
    rd(`ETI_OFF_STATUS, 32'h1, `ETI_RESP_OKAY);
    repeat (500) @(posedge aclk);
    rd(`ETI_OFF_STATUS, 32'h0002_0003, `ETI_RESP_OKAY);
    wr(`ETI_OFF_CTRL, 32'h0000_0111);
    wr(`ETI_OFF_TRIGGER, 32'h1);
    repeat (20) @(negedge aclk);
    `CHK("alarm", 1'b1, alarm_active)
    @(posedge aclk);
    send(11'h2, 1'b0, 4'h1, 2'h1);
    drain("alarm");
    close_out();
  end
endmodule : tb
